// [hw/tcm_cfg.svh]
// tcm_cfg.svh: field positions, codes and reset values of the count-mode control block
// assumes: included by bare name from the package and the design modules
`ifndef TCM_CFG_SVH
`define TCM_CFG_SVH
`define TCM_DIV_HI 9
`define TCM_DIV_LO 8
`define TCM_PRELOAD_BIT 7
`define TCM_ALIGN_HI 6
`define TCM_ALIGN_LO 5
`define TCM_DIR_BIT 4
`define TCM_DIV_BY1 2'h0
`define TCM_DIV_BY2 2'h1
`define TCM_DIV_BY4 2'h2
`define TCM_DIV_RSVD 2'h3
`define TCM_MODE_EDGE 2'h0
`define TCM_MODE_CTR1 2'h1
`define TCM_MODE_CTR2 2'h2
`define TCM_MODE_CTR3 2'h3
`define TCM_CHAN_OUT 2'h0
`define TCM_CTRL_RST 10'h000
`define TCM_ARR_RST 16'hFFFF
`define TCM_CNT_ZERO 16'h0000
`define TCM_CNT_ONE 16'h0001
`define TCM_PRE_ZERO 2'h0
`define TCM_PRE_ONE 2'h1
`define TCM_PRE_THREE 2'h3
`endif

// [hw/tcm_pkg.sv]
// tcm_pkg.sv: types shared by the count-mode control block
// assumes: tcm_cfg.svh on the include path
package tcm_pkg;
  `include "tcm_cfg.svh"
  typedef enum logic [1:0]
  {
    TCM_ALIGN_EDGE = 2'b00,
    TCM_ALIGN_CTR1 = 2'b01,
    TCM_ALIGN_CTR2 = 2'b10,
    TCM_ALIGN_CTR3 = 2'b11
  } tcm_align_e;
endpackage : tcm_pkg

// [hw/tcm_sample_div.sv]
// tcm_sample_div.sv: sampling-clock tick generator for dead-band and input filters
// assumes: one kernel clock; code 11 is never programmed by software
module tcm_sample_div
  import tcm_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_div,
  output logic o_tick
);
  `include "tcm_cfg.svh"
  typedef struct packed
  {
    logic [1:0] pre;
    logic tick;
  } tcm_div_s;
  tcm_div_s st_ff;
  tcm_div_s nxt_st;
  logic [1:0] last_pre;

  ////////////////////////////////////////////////////////////////////////////
  // terminal prescale count per code; reserved code treated as div1
  always_comb
  begin
    unique case (i_div)
      `TCM_DIV_BY2: last_pre = `TCM_PRE_ONE;
      `TCM_DIV_BY4: last_pre = `TCM_PRE_THREE;
      default: last_pre = `TCM_PRE_ZERO;
    endcase
  end

  // free-running prescaler, tick on wrap
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.tick = (st_ff.pre >= last_pre);
    nxt_st.pre = nxt_st.tick ? `TCM_PRE_ZERO : st_ff.pre + `TCM_PRE_ONE;
  end

  // state register; tick is registered so consumers see a clean pulse
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign o_tick = st_ff.tick;

  // div1 gives a tick every cycle once running
  div1_every_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_div == `TCM_DIV_BY1) [*3] |-> o_tick) else $error("div1 tick missing");
  // div4 ticks are four cycles apart; looks back so a later code change cannot trip it
  div4_spacing_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    ((i_div == `TCM_DIV_BY4) [*8] ##0 o_tick) |-> ($past(o_tick, 4) && !$past(o_tick, 1)
      && !$past(o_tick, 2) && !$past(o_tick, 3))) else $error("div4 spacing wrong");
endmodule : tcm_sample_div

// [hw/tcm_count_ctrl.sv]
// tcm_count_ctrl.sv: count-mode control of a 16-bit advanced timer
// assumes: control fields come as plain ports; compare core supplies raw match events
// How it works
// - divider code 00, 01, 10 gives a sample tick every 1, 2 or 4 kernel clocks.
// - with preload off a reload write acts at once, with it on it waits in a shadow for update.
// - alignment 00 counts in one direction set by the direction bit.
// - alignment 01 alternates and raises output compare flags only while counting down.
// - alignment 10 alternates and raises output compare flags only while counting up.
// - alignment 11 alternates and raises output compare flags in both directions.
// - compare flags are raised only on channels whose direction select is 00; other channels never flag.
// - edge to center alignment switches are refused while the counter runs.
// - in edge mode direction 0 counts up and 1 counts down.
// - in center or encoder mode the direction bit ignores writes and shows hardware direction.
// - the divided sample tick goes to the dead-band generator and the input filters.
// - alignment sits at bits 6:5, preload enable at bit 7, divider at bits 9:8.
module tcm_count_ctrl
  import tcm_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int CH_N = 6
)
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ctrl_we,
  input wire logic [9:0] i_ctrl_wdata,
  input wire logic i_encoder_mode,
  input wire logic i_encoder_dir,
  input wire logic i_counter_enable_bit,
  input wire logic i_arr_we,
  input wire logic [CNT_W-1:0] i_arr_wdata,
  input wire logic i_update_evt,
  input wire logic [CH_N-1:0] i_cmp_match,
  input wire logic [2*CH_N-1:0] i_channel_direction_select,
  output logic [9:0] o_ctrl_rdata,
  output logic [1:0] o_sample_clock_divider,
  output logic o_reload_preload_enable,
  output logic [1:0] o_alignment_mode_select,
  output logic o_dir,
  output logic [CNT_W-1:0] o_auto_reload_value,
  output logic [CNT_W-1:0] o_arr_preload,
  output logic [CNT_W-1:0] o_count,
  output logic [CH_N-1:0] o_cmp_flag_set,
  output logic o_sample_tick,
  output logic o_deadband_tick,
  output logic o_filter_tick
);
  `include "tcm_cfg.svh"

  typedef struct packed
  {
    logic [1:0] div_sel;
    logic preload_en;
    tcm_align_e align;
    logic dir;
    logic [CNT_W-1:0] arr_act;
    logic [CNT_W-1:0] arr_pre;
    logic [CNT_W-1:0] cnt;
    logic [CH_N-1:0] flag;
  } tcm_ctl_s;

  tcm_ctl_s st_ff;
  tcm_ctl_s nxt_st;
  logic center;
  logic tick;
  tcm_align_e wr_align;
  logic [CNT_W-1:0] arr_now;

  // center-aligned test, used on stored and written modes
  function automatic logic is_center(input tcm_align_e m);
    is_center = (m != TCM_ALIGN_EDGE);
  endfunction : is_center

  // output channel qualification of a raw match against counting direction
  function automatic logic flag_ok(input tcm_align_e m, input logic down);
    unique case (m)
      TCM_ALIGN_CTR1: flag_ok = down;
      TCM_ALIGN_CTR2: flag_ok = !down;
      default: flag_ok = 1'b1;
    endcase
  endfunction : flag_ok

  ////////////////////////////////////////////////////////////////////////////
  // sampling clock divider shared by dead-band and filters
  tcm_sample_div u_div
  (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_div(st_ff.div_sel),
    .o_tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign center = is_center(st_ff.align);
  assign wr_align = tcm_align_e'(i_ctrl_wdata[`TCM_ALIGN_HI:`TCM_ALIGN_LO]);
  // reload value in force this cycle; active copy only, a direct write shows from the next edge
  assign arr_now = st_ff.arr_act;

  // next-state: control fields, reload, counter, compare flags
  always_comb
  begin
    nxt_st = st_ff;
    if (i_ctrl_we)
    begin
      nxt_st.div_sel = i_ctrl_wdata[`TCM_DIV_HI:`TCM_DIV_LO];
      nxt_st.preload_en = i_ctrl_wdata[`TCM_PRELOAD_BIT];
      // edge to center while running is refused, mode kept
      if (!(i_counter_enable_bit && !center && is_center(wr_align)))
        nxt_st.align = wr_align;
      // direction is writable only in edge mode, not encoder
      if (!is_center(nxt_st.align) && !i_encoder_mode)
        nxt_st.dir = i_ctrl_wdata[`TCM_DIR_BIT];
    end
    if (i_arr_we)
    begin
      nxt_st.arr_pre = i_arr_wdata;
      if (!st_ff.preload_en)
        nxt_st.arr_act = i_arr_wdata;
    end
    if (i_update_evt && st_ff.preload_en)
      nxt_st.arr_act = st_ff.arr_pre;
    if (i_encoder_mode)
      nxt_st.dir = i_encoder_dir;
    else if (i_counter_enable_bit)
    begin
      if (center)
      begin
        // turn at reload going up and at zero going down
        if (!st_ff.dir && st_ff.cnt >= arr_now)
        begin
          nxt_st.dir = 1'b1;
          nxt_st.cnt = st_ff.cnt - `TCM_CNT_ONE;
        end
        else if (st_ff.dir && st_ff.cnt == `TCM_CNT_ZERO)
        begin
          nxt_st.dir = 1'b0;
          nxt_st.cnt = `TCM_CNT_ONE;
        end
        else
          nxt_st.cnt = st_ff.dir ? st_ff.cnt - `TCM_CNT_ONE : st_ff.cnt + `TCM_CNT_ONE;
      end
      else if (!st_ff.dir)
        nxt_st.cnt = (st_ff.cnt >= arr_now) ? `TCM_CNT_ZERO : st_ff.cnt + `TCM_CNT_ONE;
      else
        nxt_st.cnt = (st_ff.cnt == `TCM_CNT_ZERO) ? arr_now : st_ff.cnt - `TCM_CNT_ONE;
    end
    // one-cycle compare flag pulses for output channels only
    for (int c = 0; c < CH_N; c++)
      nxt_st.flag[c] = i_cmp_match[c]
        && (i_channel_direction_select[2*c +: 2] == `TCM_CHAN_OUT)
        && flag_ok(st_ff.align, st_ff.dir);
  end

  // state register; reload copies come up at all ones so a stray enable wraps late
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff <= '0;
      st_ff.arr_act <= `TCM_ARR_RST;
      st_ff.arr_pre <= `TCM_ARR_RST;
    end
    else
      st_ff <= nxt_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // readback and field outputs, all from flops
  assign o_sample_clock_divider = st_ff.div_sel;
  assign o_reload_preload_enable = st_ff.preload_en;
  assign o_alignment_mode_select = st_ff.align;
  assign o_dir = st_ff.dir;
  assign o_ctrl_rdata = {st_ff.div_sel, st_ff.preload_en, st_ff.align, st_ff.dir, 4'h0};
  assign o_auto_reload_value = st_ff.arr_act;
  assign o_arr_preload = st_ff.arr_pre;
  assign o_count = st_ff.cnt;
  assign o_cmp_flag_set = st_ff.flag;
  // same tick to both consumers keeps filter and dead-band in step
  assign o_sample_tick = tick;
  assign o_deadband_tick = tick;
  assign o_filter_tick = tick;

  ////////////////////////////////////////////////////////////////////////////
  // properties watch registered fields, so each looks one edge past its cause
  edge_ctr_block_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ctrl_we && i_counter_enable_bit && o_alignment_mode_select == `TCM_MODE_EDGE)
    |=> o_alignment_mode_select == `TCM_MODE_EDGE) else $error("mode switched while running");
  dir_ro_center_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ctrl_we && !i_encoder_mode && !i_counter_enable_bit && center && is_center(wr_align))
    |=> $stable(o_dir)) else $error("direction written in center mode");
  arr_direct_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_arr_we && !o_reload_preload_enable && !i_update_evt)
    |=> o_auto_reload_value == $past(i_arr_wdata)) else $error("direct reload lost");
  arr_shadow_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!i_update_evt && o_reload_preload_enable) |=> $stable(o_auto_reload_value))
    else $error("shadowed reload changed early");
  edge_up_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_counter_enable_bit && !i_encoder_mode && !center && !o_dir
      && o_count < o_auto_reload_value)
    |=> o_count == $past(o_count) + `TCM_CNT_ONE) else $error("edge up count wrong");
  edge_down_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_counter_enable_bit && !i_encoder_mode && !center && o_dir && o_count != `TCM_CNT_ZERO)
    |=> o_count == $past(o_count) - `TCM_CNT_ONE) else $error("edge down count wrong");
  ctr_turn_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_counter_enable_bit && !i_encoder_mode && !i_ctrl_we && center && o_dir
      && o_count == `TCM_CNT_ZERO) |=> !o_dir) else $error("no turn at zero");
  ctr1_down_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (o_alignment_mode_select == `TCM_MODE_CTR1 && !o_dir) |=> o_cmp_flag_set == '0)
    else $error("flag set counting up in mode 1");
  ctr2_up_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (o_alignment_mode_select == `TCM_MODE_CTR2 && o_dir) |=> o_cmp_flag_set == '0)
    else $error("flag set counting down in mode 2");
  ctr3_both_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (o_alignment_mode_select == `TCM_MODE_CTR3 && i_cmp_match[0]
      && i_channel_direction_select[1:0] == `TCM_CHAN_OUT) |=> o_cmp_flag_set[0])
    else $error("mode 3 flag missing");
  out_only_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_channel_direction_select[3:2] != `TCM_CHAN_OUT) |=> !o_cmp_flag_set[1])
    else $error("input channel flagged");
  in_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_channel_direction_select[9:8] != `TCM_CHAN_OUT) |=> !o_cmp_flag_set[4])
    else $error("input channel four flagged");
endmodule : tcm_count_ctrl

// [testbench/tb_top.sv]
// tb_top.sv: self-checking bench for the count-mode control block
// assumes: tcm_pkg compiled first; design assertions live inside the design
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import tcm_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic we = 1'b0, enc = 1'b0, enc_dir = 1'b0, en = 1'b0, arr_we = 1'b0, upd = 1'b0;
  logic [9:0] wd = 10'h000;
  logic [15:0] arr_wd = 16'h0000;
  logic [5:0] match = 6'h00;
  logic [9:0] rdata;
  logic [1:0] div, align;
  logic pre, dir, stk, dtk, ftk;
  logic [15:0] arr, shadow, cnt;
  logic [5:0] flags;
  int err_count = 0, cmp_count = 0, cyc = 0, nt;
  // channel 1 is an input, channel 4 is in another mode: both must stay silent
  localparam logic [11:0] SEL = 12'h304;
  localparam logic [5:0] MASK = 6'h2D;
  ////////////////////////////////////////////////////////////////////////////////
  tcm_count_ctrl dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ctrl_we(we), .i_ctrl_wdata(wd),
    .i_encoder_mode(enc), .i_encoder_dir(enc_dir), .i_counter_enable_bit(en),
    .i_arr_we(arr_we), .i_arr_wdata(arr_wd), .i_update_evt(upd), .i_cmp_match(match),
    .i_channel_direction_select(SEL), .o_ctrl_rdata(rdata), .o_sample_clock_divider(div),
    .o_reload_preload_enable(pre), .o_alignment_mode_select(align), .o_dir(dir),
    .o_auto_reload_value(arr), .o_arr_preload(shadow), .o_count(cnt), .o_cmp_flag_set(flags),
    .o_sample_tick(stk), .o_deadband_tick(dtk), .o_filter_tick(ftk));
  // 200 MHz kernel clock
  initial
  begin
    forever #2.5 i_mclk = ~i_mclk;
  end
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // reset held 16 cycles, released on an edge
  task automatic do_reset();
    @(posedge i_mclk) i_rst_n <= 1'b0;
    repeat (16) @(posedge i_mclk);
    i_rst_n <= 1'b1;
  endtask : do_reset
  // one-cycle control write; fields show right after the taking edge
  task automatic wr_ctrl(input logic [1:0] d, input logic p, input logic [1:0] m, input logic r);
    @(posedge i_mclk)
    begin
      we <= 1'b1;
      wd <= {d, p, m, r, 4'h0};
    end
    @(posedge i_mclk) we <= 1'b0;
    #1;
  endtask : wr_ctrl
  task automatic wr_arr(input logic [15:0] v);
    @(posedge i_mclk)
    begin
      arr_we <= 1'b1;
      arr_wd <= v;
    end
    @(posedge i_mclk) arr_we <= 1'b0;
    #1;
  endtask : wr_arr
  // enable for exactly n counting edges
  task automatic run(input int n);
    @(posedge i_mclk) en <= 1'b1;
    repeat (n) @(posedge i_mclk);
    en <= 1'b0;
    #1;
  endtask : run
  // all six channels match together; only qualified outputs may flag, for one cycle
  task automatic flg(input logic [5:0] exp);
    @(posedge i_mclk) match <= 6'h3F;
    @(posedge i_mclk) match <= 6'h00;
    #1 chk(flags, exp);
    @(posedge i_mclk) #1 chk(flags, 6'h00);
  endtask : flg
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (16) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    #1 chk(rdata, 10'h000);
    chk(arr, 16'hFFFF);
    // divided sample tick: 8 cycles hold 8, 4, 2 ticks
    // codes 00 to 10 only; 11 is reserved and never written
    for (int d = 0; d < 3; d++)
    begin
      wr_ctrl(d[1:0], 1'b0, 2'h0, 1'b0);
      chk(rdata, {d[1:0], 8'h00});
      chk(div, d[1:0]);
      nt = 0;
      repeat (8)
      begin
        @(posedge i_mclk) #1 nt += int'(stk);
        chk({dtk, ftk}, {stk, stk});
      end
      chk(nt[15:0], 16'(8 >> d));
    end
    // direct reload then edge counting up and down
    wr_ctrl(2'h0, 1'b0, 2'h0, 1'b0);
    wr_arr(16'h0004);
    chk(arr, 16'h0004);
    run(7);
    chk(cnt, 16'h0002);
    wr_ctrl(2'h0, 1'b0, 2'h0, 1'b1);
    chk(rdata, 10'h010);
    run(4);
    chk(cnt, 16'h0003);
    // encoder mode hands the direction to hardware
    @(posedge i_mclk) enc <= 1'b1;
    repeat (2) @(posedge i_mclk);
    #1 chk(dir, 1'b0);
    @(posedge i_mclk) enc_dir <= 1'b1;
    @(posedge i_mclk) #1 chk(dir, 1'b1);
    @(posedge i_mclk)
    begin
      enc <= 1'b0;
      enc_dir <= 1'b0;
    end
    // buffered reload waits for the update event
    wr_ctrl(2'h0, 1'b1, 2'h0, 1'b0);
    chk(pre, 1'b1);
    wr_arr(16'h0009);
    chk(shadow, 16'h0009);
    chk(arr, 16'h0004);
    @(posedge i_mclk) upd <= 1'b1;
    @(posedge i_mclk) upd <= 1'b0;
    #1 chk(arr, 16'h0009);
    // edge to center while running is refused
    @(posedge i_mclk) en <= 1'b1;
    wr_ctrl(2'h0, 1'b0, 2'h1, 1'b0);
    chk(align, 2'h0);
    @(posedge i_mclk) en <= 1'b0;
    do_reset();
    // center counting turns at the reload value and at zero
    wr_arr(16'h0003);
    wr_ctrl(2'h0, 1'b0, TCM_ALIGN_CTR3, 1'b0);
    run(4);
    chk(cnt, 16'h0002);
    chk(dir, 1'b1);
    run(3);
    chk(cnt, 16'h0001);
    chk(dir, 1'b0);
    // every alignment mode in both directions; center writes try the wrong direction
    do_reset();
    for (int d = 0; d < 2; d++)
    begin
      for (int m = 0; m < 4; m++)
      begin
        wr_ctrl(2'h0, 1'b0, m[1:0], (m == 0) ? d[0] : ~d[0]);
        chk(dir, d[0]);
        flg(((m == 1 && d == 0) || (m == 2 && d == 1)) ? 6'h00 : MASK);
      end
    end
    end_of_test();
  end
endmodule : tb_top
